// *** logic/dpra_regs.svh ***
// Constants for the two-port register array: indices, field positions and bank codes.
`ifndef DPRA_REGS_SVH
`define DPRA_REGS_SVH

// Number of byte registers in the array.
`define DPRA_REG_COUNT 16
// First flag register (write-protect bits and flags of registers 2 to 7).
`define DPRA_FLAG_LO_REG 4'h0
// Second flag register (flags of registers 8 to 15).
`define DPRA_FLAG_HI_REG 4'h1
// Lowest general-purpose register index.
`define DPRA_FIRST_GP_REG 2
// Bit positions in the first flag register, bit 0 being the most significant line.
`define DPRA_WP_LOW_BIT 0
`define DPRA_WP_HIGH_BIT 1
// Registers guarded by the two write-protect bits.
`define DPRA_WP_LOW_REG 4'hE
`define DPRA_WP_HIGH_REG 4'hF
// Even register of the pair used by DMA in word mode with index bit 0 low.
`define DPRA_DMA_LO_PAIR 4'hC
// Even register of the pair used by DMA otherwise.
`define DPRA_DMA_HI_PAIR 4'hE
// Upper nibble of a secondary-bus address that selects this array (octal 60 to 77).
`define DPRA_SEC_BANK 4'h3

`endif

// *** logic/dpra_pkg.sv ***
// Types shared by both ends of the two-port register array link.
package dpra_pkg;

  // One register byte; index 0 is the most significant line.
  typedef logic [0:7] dpra_byte_t;

  // Operations the secondary-side controller can run.
  typedef enum logic [1:0] {
    SOP_SELECT,
    SOP_WRITE,
    SOP_READ
  } dpra_sop_t;

  // Sequencing phases of one transfer on either port.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SETUP,
    PH_STROBE,
    PH_HOLD
  } dpra_phase_t;

  // Whole state of the array end.
  typedef struct packed {
    logic [15:0][0:7] arr;
    logic sel_valid;
    logic [3:0] sel_idx;
    logic ws_q;
    logic mclk_q;
    logic [0:15] lanes_q;
    logic [0:7] sec_q;
  } dpra_dev_state_t;

  // Whole state of the partner end.
  typedef struct packed {
    dpra_phase_t hph;
    logic dma_n;
    logic pio_n;
    logic rd;
    logic byte_mode;
    logic [3:0] idx;
    logic [15:0] wdata;
    logic drive;
    logic ws;
    logic [15:0] hrdata;
    logic hdone;
    dpra_phase_t sph;
    logic me_n;
    logic sc;
    logic wc;
    logic mclk;
    logic [7:0] iv;
    logic iv_drive;
    logic [7:0] srdata;
    logic sdone;
  } dpra_ptn_state_t;

endpackage

// *** logic/dpra_if.sv ***
// Pin-level link between the register array and its host and controller partners.
`timescale 1ns/10ps
`default_nettype none

interface dpra_if;
  logic direct_access_enable_n;
  logic programmed_io_enable_n;
  logic host_read;
  logic byte_mode;
  logic [3:0] host_reg_index;
  logic host_write_pulse;
  logic [0:15] host_data_lanes;
  logic [0:15] lanes_dev_out;
  logic [0:15] lanes_dev_oe;
  logic [0:15] lanes_host_out;
  logic [0:15] lanes_host_oe;
  logic secondary_port_select_n;
  logic mclk;
  logic address_phase_cmd;
  logic write_phase_cmd;
  logic [0:7] secondary_bus;
  logic [0:7] sec_dev_out;
  logic [0:7] sec_dev_oe;
  logic [0:7] sec_ctl_out;
  logic [0:7] sec_ctl_oe;

  // Undriven lines float high, as with pull-ups on the board.
  assign host_data_lanes = (lanes_dev_oe & lanes_dev_out)
    | (~lanes_dev_oe & lanes_host_oe & lanes_host_out)
    | (~lanes_dev_oe & ~lanes_host_oe);
  assign secondary_bus = (sec_dev_oe & sec_dev_out)
    | (~sec_dev_oe & sec_ctl_oe & sec_ctl_out)
    | (~sec_dev_oe & ~sec_ctl_oe);

  modport array (
    input direct_access_enable_n, programmed_io_enable_n, host_read, byte_mode,
    input host_reg_index, host_write_pulse, host_data_lanes,
    input secondary_port_select_n, mclk, address_phase_cmd, write_phase_cmd, secondary_bus,
    output lanes_dev_out, lanes_dev_oe, sec_dev_out, sec_dev_oe
  );

  modport partner (
    output direct_access_enable_n, programmed_io_enable_n, host_read, byte_mode,
    output host_reg_index, host_write_pulse, lanes_host_out, lanes_host_oe,
    output secondary_port_select_n, mclk, address_phase_cmd, write_phase_cmd,
    output sec_ctl_out, sec_ctl_oe,
    input host_data_lanes, secondary_bus
  );
endinterface // dpra_if

`default_nettype wire

// *** logic/dpra_partner_end.sv ***
// Partner end: host bus sequencer and secondary-side controller bus sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "dpra_regs.svh"

module dpra_partner_end
  import dpra_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  dpra_if.partner bus,
  input wire logic hreq_i,
  input wire logic hwrite_i,
  input wire logic hbyte_i,
  input wire logic hdma_i,
  input wire logic [3:0] hidx_i,
  input wire logic [15:0] hwdata_i,
  output logic hready_o,
  output logic hdone_o,
  output logic [15:0] hrdata_o,
  input wire logic sreq_i,
  input wire dpra_sop_t sop_i,
  input wire logic [7:0] sdata_i,
  output logic sready_o,
  output logic sdone_o,
  output logic [7:0] srdata_o
);

  dpra_ptn_state_t st_reg;
  dpra_ptn_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.hdone = 1'b0;
    st_next.sdone = 1'b0;
    unique case (st_reg.hph)
      PH_IDLE:
      begin
        if (hreq_i)
        begin
          st_next.dma_n = !hdma_i;
          st_next.pio_n = hdma_i;
          st_next.rd = !hwrite_i;
          st_next.byte_mode = hbyte_i;
          st_next.idx = hidx_i;
          st_next.wdata = hwdata_i;
          st_next.drive = hwrite_i;
          st_next.hph = PH_SETUP;
        end
      end
      PH_SETUP:
      begin
        st_next.ws = !st_reg.rd;
        st_next.hph = PH_STROBE;
      end
      PH_STROBE:
      begin
        st_next.ws = 1'b0;
        if (st_reg.rd)
        begin
          st_next.hrdata = bus.host_data_lanes;
        end
        st_next.hph = PH_HOLD;
      end
      PH_HOLD:
      begin
        st_next.dma_n = 1'b1;
        st_next.pio_n = 1'b1;
        st_next.rd = 1'b1;
        st_next.drive = 1'b0;
        st_next.hdone = 1'b1;
        st_next.hph = PH_IDLE;
      end
    endcase
    unique case (st_reg.sph)
      PH_IDLE:
      begin
        if (sreq_i)
        begin
          st_next.me_n = 1'b0;
          st_next.sc = (sop_i == SOP_SELECT);
          st_next.wc = (sop_i == SOP_WRITE);
          st_next.iv = sdata_i;
          st_next.iv_drive = (sop_i != SOP_READ);
          st_next.sph = PH_SETUP;
        end
      end
      PH_SETUP:
      begin
        st_next.mclk = 1'b1;
        st_next.sph = PH_STROBE;
      end
      PH_STROBE:
      begin
        st_next.mclk = 1'b0;
        if (!st_reg.sc && !st_reg.wc)
        begin
          st_next.srdata = bus.secondary_bus;
        end
        st_next.sph = PH_HOLD;
      end
      PH_HOLD:
      begin
        st_next.me_n = 1'b1;
        st_next.sc = 1'b0;
        st_next.wc = 1'b0;
        st_next.iv_drive = 1'b0;
        st_next.sdone = 1'b1;
        st_next.sph = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= '0;
      st_reg.dma_n <= 1'b1;
      st_reg.pio_n <= 1'b1;
      st_reg.rd <= 1'b1;
      st_reg.me_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus.direct_access_enable_n = st_reg.dma_n;
  assign bus.programmed_io_enable_n = st_reg.pio_n;
  assign bus.host_read = st_reg.rd;
  assign bus.byte_mode = st_reg.byte_mode;
  assign bus.host_reg_index = st_reg.idx;
  assign bus.host_write_pulse = st_reg.ws;
  assign bus.lanes_host_out = st_reg.wdata;
  assign bus.lanes_host_oe = {16{st_reg.drive}};
  assign bus.secondary_port_select_n = st_reg.me_n;
  assign bus.mclk = st_reg.mclk;
  assign bus.address_phase_cmd = st_reg.sc;
  assign bus.write_phase_cmd = st_reg.wc;
  assign bus.sec_ctl_out = st_reg.iv;
  assign bus.sec_ctl_oe = {8{st_reg.iv_drive}};

  assign hready_o = (st_reg.hph == PH_IDLE);
  assign hdone_o = st_reg.hdone;
  assign hrdata_o = st_reg.hrdata;
  assign sready_o = (st_reg.sph == PH_IDLE);
  assign sdone_o = st_reg.sdone;
  assign srdata_o = st_reg.srdata;

endmodule // dpra_partner_end

`default_nettype wire

// *** logic/dpra_array_end.sv ***
// Array end: sixteen-byte two-port register array with host and controller port logic.
`timescale 1ns/10ps
`default_nettype none
`include "dpra_regs.svh"

module dpra_array_end
  import dpra_pkg::*;
#(
  parameter int REG_COUNT = `DPRA_REG_COUNT
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  dpra_if.array bus,
  output logic [15:0] flag_view_o,
  output logic sec_selected_o
);

  if (REG_COUNT != `DPRA_REG_COUNT)
  begin : g_bad_count
    $error("dpra_array_end serves exactly sixteen registers");
  end

  dpra_dev_state_t st_reg;
  dpra_dev_state_t st_next;

  logic is_dma;
  logic is_pio;
  logic host_on;
  logic [3:0] pair_base;
  logic [3:0] pair_odd;
  logic lane_a_on;
  logic lane_b_on;
  logic host_wr;
  logic sec_on;
  logic sec_strobe;
  logic sec_read;
  logic [0:1] lane_wr;
  logic wp_low_on;
  logic wp_high_on;
  logic sec_select;
  logic sec_store;

  // host port mode decode
  // DMA takes precedence whenever both enables are low.
  assign is_dma = !bus.direct_access_enable_n;
  assign is_pio = !bus.programmed_io_enable_n && bus.direct_access_enable_n;
  assign host_on = is_dma || is_pio;

  // DMA fixed pair choice
  // DMA ignores the upper index lines; only bit 0 picks the pair or byte.
  assign pair_base = is_dma
    ? ((bus.byte_mode || bus.host_reg_index[0]) ? `DPRA_DMA_HI_PAIR : `DPRA_DMA_LO_PAIR)
    : {bus.host_reg_index[3:1], 1'b0};
  assign pair_odd = {pair_base[3:1], 1'b1};

  assign lane_a_on = host_on && (!bus.byte_mode || !bus.host_reg_index[0]);
  assign lane_b_on = host_on && (!bus.byte_mode || bus.host_reg_index[0]);

  // write on pulse rise
  // Acting on the rising edge gives one store per pulse, however long it is held.
  assign host_wr = bus.host_write_pulse && !st_reg.ws_q && host_on && !bus.host_read;

  // byte writes touch one lane only
  // A word write stores both lanes on the same edge.
  assign lane_wr = {host_wr && lane_a_on, host_wr && lane_b_on};

  // protect bits in flag register
  // Both come from the registers, so a protect change acts from the next write on.
  assign wp_low_on = st_reg.arr[`DPRA_FLAG_LO_REG][`DPRA_WP_LOW_BIT];
  assign wp_high_on = st_reg.arr[`DPRA_FLAG_LO_REG][`DPRA_WP_HIGH_BIT];

  assign sec_on = !bus.secondary_port_select_n;
  assign sec_strobe = sec_on && bus.mclk && !st_reg.mclk_q;

  // address phase decode
  // A cycle with both commands high is neither phase, so the array ignores it.
  assign sec_select = sec_strobe && bus.address_phase_cmd && !bus.write_phase_cmd;
  // write phase needs selection
  // Without a selection the write phase falls on no register.
  assign sec_store = sec_strobe && bus.write_phase_cmd && !bus.address_phase_cmd
    && st_reg.sel_valid;

  always_comb
  begin
    logic [15:0] written;
    logic [3:0] tgt;
    dpra_byte_t din;
    written = '0;
    tgt = '0;
    din = '0;
    st_next = st_reg;
    st_next.ws_q = bus.host_write_pulse;
    st_next.mclk_q = bus.mclk;

    for (int l = 0; l < 2; l++)
    begin
      tgt = (l == 0) ? pair_base : pair_odd;
      din = bus.host_data_lanes[8 * l +: 8];
      if (lane_wr[l])
      begin
        if (!(tgt == `DPRA_WP_LOW_REG && wp_low_on)
          && !(tgt == `DPRA_WP_HIGH_REG && wp_high_on))
        begin
          st_next.arr[tgt] = din;
          written[tgt] = 1'b1;
          if (tgt == `DPRA_FLAG_LO_REG)
          begin
            st_next.arr[tgt][`DPRA_WP_LOW_BIT] = st_reg.arr[tgt][`DPRA_WP_LOW_BIT];
            st_next.arr[tgt][`DPRA_WP_HIGH_BIT] = st_reg.arr[tgt][`DPRA_WP_HIGH_BIT];
          end
        end
      end
    end

    if (sec_select)
    begin
      st_next.sel_valid = (bus.secondary_bus[0:3] == `DPRA_SEC_BANK);
      st_next.sel_idx = bus.secondary_bus[4:7];
    end

    if (sec_store)
    begin
      // secondary store after host
      // Only a same-register collision loses the host byte; the controller wins there.
      st_next.arr[st_reg.sel_idx] = bus.secondary_bus;
      written[st_reg.sel_idx] = 1'b1;
    end

    // automatic flag set
    // Applied last so that a flag set beats a clear written in the same cycle.
    for (int r = `DPRA_FIRST_GP_REG; r < REG_COUNT; r++)
    begin
      if (written[r])
      begin
        st_next.arr[{3'b000, r[3]}][r[2:0]] = 1'b1;
      end
    end

    // Read data leaves from flip-flops: the lanes carry the pair of this cycle's index
    // one cycle later, which is safe because the host samples late in its access.
    st_next.lanes_q = {st_next.arr[pair_base], st_next.arr[pair_odd]};
    st_next.sec_q = st_next.arr[st_next.sel_idx];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // disabled mode drives nothing
  // Enables stay combinational so the lanes float in the very cycle the mode drops.
  assign bus.lanes_dev_oe = {{8{lane_a_on && bus.host_read}}, {8{lane_b_on && bus.host_read}}};
  assign bus.lanes_dev_out = st_reg.lanes_q;

  // The array answers a controller input phase: selected, enabled and no command high.
  // secondary bus read drive
  assign sec_read = sec_on && !bus.address_phase_cmd && !bus.write_phase_cmd
    && st_reg.sel_valid;
  assign bus.sec_dev_oe = {8{sec_read}};
  assign bus.sec_dev_out = st_reg.sec_q;

  assign flag_view_o = {st_reg.arr[`DPRA_FLAG_LO_REG], st_reg.arr[`DPRA_FLAG_HI_REG]};
  assign sec_selected_o = st_reg.sel_valid;

endmodule // dpra_array_end

`default_nettype wire

// *** dv/dpra_link_asserts.sv ***
// Pin-level assertions on the link between the array end and the partner end.
`timescale 1ns/10ps
`default_nettype none

module dpra_link_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic direct_access_enable_n,
  input wire logic programmed_io_enable_n,
  input wire logic host_read,
  input wire logic byte_mode,
  input wire logic [3:0] host_reg_index,
  input wire logic [0:15] lanes_dev_oe,
  input wire logic secondary_port_select_n,
  input wire logic address_phase_cmd,
  input wire logic write_phase_cmd,
  input wire logic [0:7] sec_dev_oe,
  input wire logic [0:7] sec_dev_out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Index bit 0 picks the lane of a byte access in both host modes.
  logic [0:15] byte_lane;
  assign byte_lane = host_reg_index[0] ? 16'h00FF : 16'hFF00;

  chk_off_no_drive: assert property (
    (programmed_io_enable_n && direct_access_enable_n) |-> lanes_dev_oe == 16'h0000)
    else $error("host lanes driven while disabled");
  chk_write_no_drive: assert property (
    !host_read |-> lanes_dev_oe == 16'h0000)
    else $error("host lanes driven in write direction");
  chk_word_read_all: assert property (
    (host_read && !byte_mode && !(programmed_io_enable_n && direct_access_enable_n))
    |-> lanes_dev_oe == 16'hFFFF)
    else $error("word read does not drive all lanes");
  chk_pio_byte_lane: assert property (
    (host_read && byte_mode && !programmed_io_enable_n && direct_access_enable_n)
    |-> lanes_dev_oe == byte_lane)
    else $error("wrong lane in byte read");
  chk_dma_byte_lane: assert property (
    (host_read && byte_mode && !direct_access_enable_n) |-> lanes_dev_oe == byte_lane)
    else $error("wrong lane in dma byte read");
  chk_sec_idle_float: assert property (
    secondary_port_select_n |-> sec_dev_oe == 8'h00)
    else $error("secondary bus driven while port not selected");
  chk_cmd_no_drive: assert property (
    (address_phase_cmd || write_phase_cmd) |-> sec_dev_oe == 8'h00)
    else $error("secondary bus driven during a command");
  chk_bus_whole: assert property (
    sec_dev_oe == 8'h00 || sec_dev_oe == 8'hFF)
    else $error("secondary bus partly driven");
  chk_sel_hold: assert property (
    (|sec_dev_oe && $past(|sec_dev_oe)) |-> $stable(sec_dev_out))
    else $error("selected register output changed");
endmodule // dpra_link_checker

`default_nettype wire

// *** dv/dual_port_register_array_ports_tb.sv ***
// Self-checking bench joining the array end and the partner end through the pin link.
`timescale 1ns/10ps
`default_nettype none

module dual_port_register_array_ports_tb
  import dpra_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hreq = 1'b0;
  logic hwrite = 1'b0;
  logic hbyte = 1'b0;
  logic hdma = 1'b0;
  logic [3:0] hidx = 4'h0;
  logic [15:0] hwdata = 16'h0000;
  logic sreq = 1'b0;
  dpra_sop_t sop = SOP_SELECT;
  logic [7:0] sdata = 8'h00;
  logic hready, hdone, sready, sdone, sec_selected;
  logic [15:0] hrdata, flag_view, hr;
  logic [7:0] srdata, sr;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #12.5 clk_i = ~clk_i;

  dpra_if link ();
  dpra_array_end #(.REG_COUNT(16)) i_dpra_array_end (.clk_i(clk_i), .rstn_i(rstn_i),
    .bus(link.array), .flag_view_o(flag_view), .sec_selected_o(sec_selected));
  dpra_partner_end i_dpra_partner_end (.clk_i(clk_i), .rstn_i(rstn_i), .bus(link.partner),
    .hreq_i(hreq), .hwrite_i(hwrite), .hbyte_i(hbyte), .hdma_i(hdma), .hidx_i(hidx),
    .hwdata_i(hwdata), .hready_o(hready), .hdone_o(hdone), .hrdata_o(hrdata),
    .sreq_i(sreq), .sop_i(sop), .sdata_i(sdata), .sready_o(sready), .sdone_o(sdone),
    .srdata_o(srdata));
  dpra_link_checker i_dpra_link_checker (.clk_i(clk_i), .rstn_i(rstn_i),
    .direct_access_enable_n(link.direct_access_enable_n),
    .programmed_io_enable_n(link.programmed_io_enable_n), .host_read(link.host_read),
    .byte_mode(link.byte_mode), .host_reg_index(link.host_reg_index),
    .lanes_dev_oe(link.lanes_dev_oe), .secondary_port_select_n(link.secondary_port_select_n),
    .address_phase_cmd(link.address_phase_cmd), .write_phase_cmd(link.write_phase_cmd),
    .sec_dev_oe(link.sec_dev_oe), .sec_dev_out(link.sec_dev_out));

  task automatic end_of_test();
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Entered just after a rising edge; the request stands until the edge that takes it.
  task automatic host(input logic w, input logic b, input logic d, input logic [3:0] idx,
    input logic [15:0] wd);
    hreq <= 1'b1;
    hwrite <= w;
    hbyte <= b;
    hdma <= d;
    hidx <= idx;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    hreq <= 1'b0;
    do @(posedge clk_i); while (hdone !== 1'b1);
    hr = hrdata;
  endtask

  task automatic sec(input dpra_sop_t op, input logic [7:0] d);
    sreq <= 1'b1;
    sop <= op;
    sdata <= d;
    do @(posedge clk_i); while (sready !== 1'b1);
    sreq <= 1'b0;
    do @(posedge clk_i); while (sdone !== 1'b1);
    sr = srdata;
  endtask

  // The watchdog allows about eighteen times the length of the whole sequence.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk("flags", 16'h0000, flag_view);
    host(1'b1, 1'b0, 1'b0, 4'h2, 16'hA55A);
    chk("flags", 16'h3000, flag_view);
    host(1'b0, 1'b0, 1'b0, 4'h3, 16'h0000);
    chk("pio word", 16'hA55A, hr);
    host(1'b1, 1'b1, 1'b0, 4'h5, 16'h00C3);
    host(1'b0, 1'b1, 1'b0, 4'h5, 16'h0000);
    chk("byte lane b", 16'hFFC3, hr);
    host(1'b0, 1'b1, 1'b0, 4'h4, 16'h0000);
    chk("byte lane a", 16'h00FF, hr);
    sec(SOP_SELECT, 8'h37);
    sec(SOP_WRITE, 8'h3C);
    chk("selected", 16'h0001, {15'h0000, sec_selected});
    host(1'b0, 1'b0, 1'b0, 4'h6, 16'h0000);
    chk("sec store", 16'h003C, hr);
    sec(SOP_READ, 8'h00);
    chk("sec read", 16'h003C, {8'h00, sr});
    sec(SOP_SELECT, 8'h50);
    chk("deselect", 16'h0000, {15'h0000, sec_selected});
    sec(SOP_WRITE, 8'hEE);
    host(1'b0, 1'b0, 1'b0, 4'h6, 16'h0000);
    chk("no store", 16'h003C, hr);
    chk("flags", 16'h3500, flag_view);
    sec(SOP_SELECT, 8'h30);
    sec(SOP_WRITE, 8'hC0);
    host(1'b1, 1'b0, 1'b0, 4'hE, 16'h1234);
    host(1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
    host(1'b0, 1'b0, 1'b0, 4'hE, 16'h0000);
    chk("protected", 16'h0000, hr);
    host(1'b0, 1'b0, 1'b0, 4'h0, 16'h0000);
    chk("protect bits", 16'hC000, hr);
    sec(SOP_WRITE, 8'h00);
    host(1'b1, 1'b0, 1'b1, 4'h1, 16'hBEEF);
    host(1'b1, 1'b0, 1'b1, 4'h0, 16'h5AA5);
    host(1'b0, 1'b0, 1'b1, 4'hF, 16'h0000);
    chk("dma word hi", 16'hBEEF, hr);
    host(1'b0, 1'b0, 1'b0, 4'hC, 16'h0000);
    chk("dma word lo", 16'h5AA5, hr);
    host(1'b0, 1'b1, 1'b1, 4'h1, 16'h0000);
    chk("dma byte b", 16'hFFEF, hr);
    host(1'b0, 1'b1, 1'b1, 4'h6, 16'h0000);
    chk("dma byte a", 16'hBEFF, hr);
    sec(SOP_SELECT, 8'h3A);
    fork
      host(1'b1, 1'b0, 1'b0, 4'h8, 16'h1122);
      sec(SOP_WRITE, 8'h77);
    join
    host(1'b0, 1'b0, 1'b0, 4'h8, 16'h0000);
    chk("both ports host", 16'h1122, hr);
    host(1'b0, 1'b0, 1'b0, 4'hA, 16'h0000);
    chk("both ports sec", 16'h7700, hr);
    chk("flags", 16'h00EF, flag_view);
    // The host clears both flag registers on the edge the controller stores register 10.
    fork
      host(1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
      sec(SOP_WRITE, 8'h55);
    join
    chk("flag set wins", 16'h0020, flag_view);
    end_of_test();
  end
endmodule // dual_port_register_array_ports_tb

`default_nettype wire
